// [rtl/phr_pkg.sv]
// Shared constants and types for the PHY identifier and advertisement bank
package phr_pkg;

  // Management register addresses
  localparam logic [4:0] REG_ID_UPPER = 5'h02;
  localparam logic [4:0] REG_ID_LOWER = 5'h03;
  localparam logic [4:0] REG_ADVERT = 5'h04;

  // Advertisement word field positions
  localparam int BIT_NEXT_PAGE = 15;
  localparam int BIT_RSV14 = 14;
  localparam int BIT_FAULT = 13;
  localparam int BIT_RSV12 = 12;
  localparam int BIT_ASYM = 11;
  localparam int BIT_PAUSE = 10;
  localparam int BIT_FOUR_PAIR = 9;
  localparam int ABIL_HI = 8;
  localparam int ABIL_LO = 5;
  localparam int SEL_HI = 4;

  // Advertisement and status values after reset
  localparam logic NEXT_PAGE_RESET = 1'h0;
  localparam logic FAULT_RESET = 1'h0;
  localparam logic ASYM_RESET = 1'h0;
  localparam logic PAUSE_RESET = 1'h0;
  localparam logic [4:0] SEL_RESET = 5'h01;
  localparam logic EXT_CAP_RESET = 1'h1;

  // Identifier field positions in the lower identifier word
  localparam int OUI_LOW_LO = 10;
  localparam int MODEL_LO = 4;

  // Management frame shape
  localparam logic [5:0] PRE_ONES = 6'h20;
  localparam logic [5:0] HDR_LAST = 6'h0C;
  localparam logic [5:0] TA_LAST = 6'h01;
  localparam logic [5:0] DATA_LAST = 6'h0F;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;

  // Pause resolution result layout
  localparam int RES_TX = 1;
  localparam int RES_RX = 0;

  // Serial management frame states
  typedef enum logic [2:0] {
    PHR_PRE,
    PHR_HDR,
    PHR_TA_RD,
    PHR_TA_WR,
    PHR_RD,
    PHR_WR
  } phr_state_t;

endpackage

// [rtl/phr_pause_res.sv]
// Pause resolution from local and partner pause advertisements
`timescale 1ns/100ps
`default_nettype none

module phr_pause_res
  import phr_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Negotiation outcome
  input wire logic an_done,
  input wire logic loc_sym,
  input wire logic loc_asym,
  input wire logic lp_sym,
  input wire logic lp_asym,
  // Result toward the PHY control register
  output logic [1:0] res
);

  typedef struct packed {
    logic [1:0] res;
  } phr_pause_state_t;

  phr_pause_state_t s_q, s_d;

  // Symmetric and asymmetric resolution, cleared while negotiation is open
  always_comb begin
    s_d = s_q;
    s_d.res = 2'h0;
    if (an_done) begin
      if (loc_sym && lp_sym) begin
        s_d.res = 2'h3;
      end else if (!loc_sym && loc_asym && lp_sym && lp_asym) begin
        s_d.res[RES_TX] = 1'h1;
      end else if (loc_sym && loc_asym && !lp_sym && lp_asym) begin
        s_d.res[RES_RX] = 1'h1;
      end
    end
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign res = s_q.res;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  both_pause_a: assert property (
    (an_done && loc_sym && lp_sym) |=> (res == 2'h3))
    else $error("symmetric pause not resolved");

  no_result_a: assert property (
    (!an_done) |=> (res == 2'h0))
    else $error("pause result present before negotiation done");

endmodule // phr_pause_res

`default_nettype wire

// [rtl/phr_regs.sv]
// Identifier and ability advertisement registers with serial management port
`timescale 1ns/100ps
`default_nettype none

// Contract
// - Two registers together give a 32-bit identifier: OUI, model, revision.
// - The identifier may instead read as zero in every bit.
// - Upper identifier at 0x02 returns OUI bits 3 to 18 in 15:0.
// - The two top OUI bits are stored in neither identifier register.
// - Lower identifier at 0x03 returns OUI bits 19 to 24 in 15:10.
// - Lower identifier bits 9:4 hold the six-bit model number.
// - Lower identifier bits 3:0 hold the four-bit revision.
// - Advertisement at 0x04 holds abilities sent to the link partner.
// - Bit 15 next-page request, read/write, resets to 0.
// - Bit 14 reserved: writes ignored, reads 0.
// - Bit 13 remote fault advertisement, read/write, resets to 0.
// - Bit 12 reserved, resets to 0, written as 0, reads 0.
// - Bit 11 asymmetric pause advertisement, read/write, resets to 0.
// - Bit 10 symmetric pause advertisement, read/write, resets to 0.
// - Resolved pause result goes to control register bits 13:12.
// - Bit 9 four-pair ability reads 0, writes have no effect.
// - Bits 8:5 speed/duplex abilities, read/write, reset from straps.
// - Bits 4:0 selector, read/write, resets to 00001.
// - Status register reports extended capability as 1.
module phr_regs
  import phr_pkg::*;
#(
  parameter logic [23:0] OUI = 24'h5A5A5A, // Arbitrary value
  parameter logic [5:0] MODEL = 6'h15, // Arbitrary value
  parameter logic [3:0] REVISION = 4'h3, // Arbitrary value
  parameter bit ID_ZERO = 1'b0
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Serial management pins
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  input wire logic [4:0] phy_addr,
  // Strap pins
  input wire logic [3:0] strap_ability,
  // Auto-negotiation engine
  input wire logic an_done,
  input wire logic lp_sym_pause,
  input wire logic lp_asym_pause,
  output logic [15:0] adv_word,
  output logic [1:0] pause_res,
  output logic ext_capable
);

  // Whole block state
  typedef struct packed {
    phr_state_t st;
    logic mdc_prev;
    logic [5:0] cnt;
    logic [12:0] hdr;
    logic [15:0] shift;
    logic out;
    logic oe;
    logic strap_done;
    logic next_page_request;
    logic remote_fault_advert;
    logic asym_pause_advert;
    logic sym_pause_advert;
    logic [3:0] ability;
    logic [4:0] selector;
    logic ext_cap;
  } phr_regs_state_t;

  // Identifier words; the top two OUI bits are dropped
  localparam logic [15:0] ID_UPPER_VAL =
    ID_ZERO ? 16'h0000 : OUI[21:6];
  localparam logic [15:0] ID_LOWER_VAL =
    ID_ZERO ? 16'h0000 : {OUI[5:0], MODEL, REVISION};

  phr_regs_state_t s_q, s_d;
  logic rise;
  logic [12:0] hdr_new;
  logic [15:0] wdata;
  logic [15:0] cur_adv;
  logic [15:0] rd_val;

  // Management clock edge and header with the new bit appended
  assign rise = mdc && !s_q.mdc_prev;
  assign hdr_new = {s_q.hdr[11:0], mdio_in};
  assign wdata = {s_q.shift[14:0], mdio_in};

  // Advertisement word as seen by the engine and by reads
  always_comb begin
    cur_adv = 16'h0000;
    cur_adv[BIT_NEXT_PAGE] = s_q.next_page_request;
    cur_adv[BIT_RSV14] = 1'h0;
    cur_adv[BIT_FAULT] = s_q.remote_fault_advert;
    cur_adv[BIT_RSV12] = 1'h0;
    cur_adv[BIT_ASYM] = s_q.asym_pause_advert;
    cur_adv[BIT_PAUSE] = s_q.sym_pause_advert;
    cur_adv[BIT_FOUR_PAIR] = 1'h0;
    cur_adv[ABIL_HI:ABIL_LO] = s_q.ability;
    cur_adv[SEL_HI:0] = s_q.selector;
  end

  // Read value for the addressed register; others read as zero
  always_comb begin
    unique case (hdr_new[4:0])
      REG_ID_UPPER: rd_val = ID_UPPER_VAL;
      REG_ID_LOWER: rd_val = ID_LOWER_VAL;
      REG_ADVERT: rd_val = cur_adv;
      default: rd_val = 16'h0000;
    endcase
  end

  // Frame engine, strap capture and register updates
  always_comb begin
    s_d = s_q;
    s_d.mdc_prev = mdc;
    s_d.ext_cap = EXT_CAP_RESET;
    // Abilities take the straps once, just after reset release
    if (!s_q.strap_done) begin
      s_d.ability = strap_ability;
      s_d.strap_done = 1'h1;
    end
    if (rise) begin
      unique case (s_q.st)
        PHR_PRE: begin
          if (mdio_in) begin
            if (s_q.cnt != PRE_ONES) begin
              s_d.cnt = s_q.cnt + 6'h01;
            end
          end else if (s_q.cnt == PRE_ONES) begin
            s_d.st = PHR_HDR;
            s_d.cnt = 6'h00;
          end else begin
            s_d.cnt = 6'h00;
          end
        end
        PHR_HDR: begin
          s_d.hdr = hdr_new;
          s_d.cnt = s_q.cnt + 6'h01;
          if (s_q.cnt == HDR_LAST) begin
            s_d.cnt = 6'h00;
            s_d.st = PHR_PRE;
            if (hdr_new[12] && hdr_new[9:5] == phy_addr) begin
              if (hdr_new[11:10] == OP_READ) begin
                s_d.st = PHR_TA_RD;
                s_d.shift = rd_val;
              end else if (hdr_new[11:10] == OP_WRITE) begin
                s_d.st = PHR_TA_WR;
              end
            end
          end
        end
        PHR_TA_RD: begin
          // First turnaround bit released, second driven low
          s_d.cnt = s_q.cnt + 6'h01;
          s_d.oe = 1'h1;
          s_d.out = 1'h0;
          if (s_q.cnt == TA_LAST) begin
            s_d.st = PHR_RD;
            s_d.cnt = 6'h00;
            s_d.out = s_q.shift[15];
          end
        end
        PHR_TA_WR: begin
          s_d.cnt = s_q.cnt + 6'h01;
          if (s_q.cnt == TA_LAST) begin
            s_d.st = PHR_WR;
            s_d.cnt = 6'h00;
          end
        end
        PHR_RD: begin
          s_d.cnt = s_q.cnt + 6'h01;
          s_d.out = s_q.shift[14];
          s_d.shift = {s_q.shift[14:0], 1'h0};
          if (s_q.cnt == DATA_LAST) begin
            s_d.st = PHR_PRE;
            s_d.cnt = 6'h00;
            s_d.oe = 1'h0;
            s_d.out = 1'h0;
          end
        end
        PHR_WR: begin
          s_d.cnt = s_q.cnt + 6'h01;
          s_d.shift = wdata;
          if (s_q.cnt == DATA_LAST) begin
            s_d.st = PHR_PRE;
            s_d.cnt = 6'h00;
            // Identifier writes fall through here unchanged
            if (s_q.hdr[4:0] == REG_ADVERT) begin
              s_d.next_page_request = wdata[BIT_NEXT_PAGE];
              s_d.remote_fault_advert = wdata[BIT_FAULT];
              s_d.asym_pause_advert = wdata[BIT_ASYM];
              s_d.sym_pause_advert = wdata[BIT_PAUSE];
              s_d.ability = wdata[ABIL_HI:ABIL_LO];
              s_d.selector = wdata[SEL_HI:0];
            end
          end
        end
      endcase
    end
  end

  // State register with documented reset values
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.st <= PHR_PRE;
      s_q.next_page_request <= NEXT_PAGE_RESET;
      s_q.remote_fault_advert <= FAULT_RESET;
      s_q.asym_pause_advert <= ASYM_RESET;
      s_q.sym_pause_advert <= PAUSE_RESET;
      s_q.selector <= SEL_RESET;
      s_q.ext_cap <= EXT_CAP_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // Pause resolution toward the PHY control register
  phr_pause_res u_pause (
    .clk(clk),
    .rst(rst),
    .an_done(an_done),
    .loc_sym(s_q.sym_pause_advert),
    .loc_asym(s_q.asym_pause_advert),
    .lp_sym(lp_sym_pause),
    .lp_asym(lp_asym_pause),
    .res(pause_res)
  );

  // Outputs straight from state flops
  assign mdio_out = s_q.out;
  assign mdio_oe = s_q.oe;
  assign adv_word = {s_q.next_page_request, 1'h0, s_q.remote_fault_advert,
    1'h0, s_q.asym_pause_advert, s_q.sym_pause_advert, 1'h0,
    s_q.ability, s_q.selector};
  assign ext_capable = s_q.ext_cap;

  // Helper strobes for the checks below
  logic wr_commit;
  logic rd_load;
  assign wr_commit = rise && s_q.st == PHR_WR && s_q.cnt == DATA_LAST;
  assign rd_load = rise && s_q.st == PHR_HDR && s_q.cnt == HDR_LAST &&
    hdr_new[12] && hdr_new[9:5] == phy_addr && hdr_new[11:10] == OP_READ;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  upper_read_a: assert property (
    (rd_load && hdr_new[4:0] == REG_ID_UPPER) |=>
      (s_q.shift == ID_UPPER_VAL && s_q.st == PHR_TA_RD))
    else $error("upper identifier not loaded for read");

  oui_drop_a: assert property (
    (rd_load && hdr_new[4:0] == REG_ID_UPPER && !ID_ZERO) |=>
      (s_q.shift == OUI[21:6]))
    else $error("upper identifier holds wrong OUI bits");

  lower_read_a: assert property (
    (rd_load && hdr_new[4:0] == REG_ID_LOWER) |=>
      (s_q.shift[15:OUI_LOW_LO] == ID_LOWER_VAL[15:OUI_LOW_LO]))
    else $error("lower identifier OUI bits wrong");

  model_rev_a: assert property (
    (rd_load && hdr_new[4:0] == REG_ID_LOWER) |=>
      (s_q.shift[9:0] == ID_LOWER_VAL[9:0]))
    else $error("model or revision field wrong");

  rev_field_a: assert property (
    (rd_load && hdr_new[4:0] == REG_ID_LOWER && !ID_ZERO) |=>
      (s_q.shift[MODEL_LO-1:0] == REVISION))
    else $error("revision field wrong");

  zero_id_a: assert property (
    (rd_load && ID_ZERO && hdr_new[4:1] == REG_ID_UPPER[4:1]) |=>
      (s_q.shift == 16'h0000))
    else $error("zero identifier option not honoured");

  id_write_a: assert property (
    (wr_commit && s_q.hdr[4:0] != REG_ADVERT) |=> $stable(adv_word))
    else $error("identifier write altered advertisement");

  adv_write_a: assert property (
    (wr_commit && s_q.hdr[4:0] == REG_ADVERT) |=>
      (adv_word[15] == $past(wdata[15]) &&
       adv_word[13] == $past(wdata[13])))
    else $error("advertisement flag write lost");

  flags_reset_a: assert property (
    (!s_q.strap_done) |-> (adv_word[BIT_NEXT_PAGE] == 1'h0 &&
      adv_word[BIT_FAULT] == 1'h0))
    else $error("next page or remote fault not clear after reset");

  reserved_a: assert property (
    adv_word[BIT_RSV14] == 1'h0 && adv_word[BIT_RSV12] == 1'h0)
    else $error("reserved advertisement bit set");

  pause_write_a: assert property (
    (wr_commit && s_q.hdr[4:0] == REG_ADVERT) |=>
      (adv_word[11:10] == $past(wdata[11:10])))
    else $error("pause advertisement write lost");

  four_pair_a: assert property (
    (wr_commit && s_q.hdr[4:0] == REG_ADVERT) |=>
      (adv_word[BIT_FOUR_PAIR] == 1'h0))
    else $error("four pair ability became set");

  strap_load_a: assert property (
    (!s_q.strap_done) |=>
      (adv_word[ABIL_HI:ABIL_LO] == $past(strap_ability)))
    else $error("strap abilities not captured");

  sel_reset_a: assert property (
    (!s_q.strap_done) |-> (adv_word[SEL_HI:0] == SEL_RESET))
    else $error("selector reset value wrong");

  ext_cap_a: assert property (
    ext_capable == 1'h1)
    else $error("extended capability flag clear");

  turn_drive_a: assert property (
    (rise && s_q.st == PHR_TA_RD && s_q.cnt == 6'h00) |=>
      (mdio_oe && !mdio_out) [*2])
    else $error("turnaround low bit not driven");

  sym_pause_a: assert property (
    (wr_commit && s_q.hdr[4:0] == REG_ADVERT) |=>
      (adv_word[BIT_PAUSE] == $past(wdata[BIT_PAUSE])))
    else $error("symmetric pause advertisement write lost");

  ability_write_a: assert property (
    (wr_commit && s_q.hdr[4:0] == REG_ADVERT) |=>
      (adv_word[ABIL_HI:ABIL_LO] == $past(wdata[ABIL_HI:ABIL_LO])))
    else $error("ability write lost");

  selector_write_a: assert property (
    (wr_commit && s_q.hdr[4:0] == REG_ADVERT) |=>
      (adv_word[SEL_HI:0] == $past(wdata[SEL_HI:0])))
    else $error("selector write lost");

  read_release_a: assert property (
    (rise && s_q.st == PHR_RD && s_q.cnt == DATA_LAST) |=>
      (!mdio_oe && s_q.st == PHR_PRE))
    else $error("wire not released after read data");

endmodule // phr_regs

`default_nettype wire

// [test/phr_mgmt_model.sv]
// Station management controller model issuing serial management frames
`timescale 1ns/100ps
`default_nettype none

module phr_mgmt_model
  import phr_pkg::*;
(
  // Clock
  input wire logic clk,
  // Management wire
  input wire logic mdio_line,
  output logic mdc,
  output logic mdio_drv,
  output logic mdio_en
);
  int half_clks;

  // Clock stands low and data is released between frames
  initial begin
    mdc = 1'b0;
    mdio_drv = 1'b0;
    mdio_en = 1'b0;
    half_clks = 4;
  end

  // One management bit: drive or release, rise, sample late in high phase
  task automatic bit_cycle(input logic en, input logic val, output logic s);
    @(posedge clk);
    mdc <= 1'b0;
    mdio_en <= en;
    mdio_drv <= val;
    repeat (half_clks) @(posedge clk);
    mdc <= 1'b1;
    repeat (half_clks) @(posedge clk);
    @(negedge clk);
    s = mdio_line;
  endtask

  // Whole frame with its own preamble; reads release the wire from TA on
  task automatic frame(input logic [1:0] op, input logic [4:0] phy,
                       input logic [4:0] reg_a, input logic [15:0] wdata,
                       output logic [15:0] rdata);
    logic [31:0] hdr;
    logic s;
    if (reg_a == REG_ADVERT) wdata[BIT_RSV12] = 1'b0;
    hdr = {2'b01, op, phy, reg_a, 2'b10, wdata};
    rdata = 16'h0000;
    for (int i = 0; i < 34; i++) bit_cycle(1'b1, 1'b1, s);
    for (int i = 31; i >= 0; i--) begin
      bit_cycle((op == OP_WRITE) || (i > 17), hdr[i], s);
      if (i > 0 && i < 17) rdata[i - 1] = s;
    end
    bit_cycle(1'b0, 1'b1, s);
    @(posedge clk);
    mdc <= 1'b0;
    mdio_en <= 1'b0;
  endtask
endmodule // phr_mgmt_model

`default_nettype wire

// [test/tb.sv]
// Testbench for the identifier and advertisement register bank
`timescale 1ns/100ps
`default_nettype none

module tb;
  import phr_pkg::*;
  localparam logic [23:0] T_OUI = 24'hC3A5E1; // Arbitrary value
  localparam logic [5:0] T_MODEL = 6'h2B; // Arbitrary value
  localparam logic [3:0] T_REV = 4'h6; // Arbitrary value
  localparam int LIMIT = 40000;
  logic clk, rst, mdio_line, an_done, lp_sym, lp_asym;
  logic mdc, mdio_drv, mdio_en, out0, oe0, out1, oe1, ext_capable;
  logic [15:0] adv_word, adv_z, rd;
  logic [1:0] pause_res;
  int errors, cmp_count, cycles;

  // Pull-up on the shared wire; whoever enables drives it
  assign mdio_line = oe0 ? out0 : (oe1 ? out1 : (mdio_en ? mdio_drv : 1'b1));

  // Device under test and an all-zero identifier device on the same wire
  phr_regs #(.OUI(T_OUI), .MODEL(T_MODEL), .REVISION(T_REV)) u_dut (
    .clk(clk), .rst(rst), .mdc(mdc), .mdio_in(mdio_line), .mdio_out(out0),
    .mdio_oe(oe0), .phy_addr(5'h01), .strap_ability(4'hA),
    .an_done(an_done), .lp_sym_pause(lp_sym), .lp_asym_pause(lp_asym),
    .adv_word(adv_word), .pause_res(pause_res), .ext_capable(ext_capable));
  phr_regs #(.ID_ZERO(1'b1)) u_zero (
    .clk(clk), .rst(rst), .mdc(mdc), .mdio_in(mdio_line), .mdio_out(out1),
    .mdio_oe(oe1), .phy_addr(5'h02), .strap_ability(4'h5),
    .an_done(an_done), .lp_sym_pause(lp_sym), .lp_asym_pause(lp_asym),
    .adv_word(adv_z), .pause_res(), .ext_capable());
  phr_mgmt_model u_mgmt (
    .clk(clk), .mdio_line(mdio_line), .mdc(mdc), .mdio_drv(mdio_drv),
    .mdio_en(mdio_en));

  // Clock generation
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Verdict and end of run
  task automatic end_of_test();
    if (errors == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      errors++;
      $display("wrong value at %0t: run did not finish", $time);
      end_of_test();
    end
  end

  // Compare a register word
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: word %h expected %h", $time, got, exp);
    end
  endtask

  // Compare a status field
  task automatic chk_res(input logic [1:0] got, input logic [1:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: status %b expected %b", $time, got, exp);
    end
  endtask

  // Register access over the management wire
  task automatic mrd(input logic [4:0] phy, input logic [4:0] ra);
    u_mgmt.frame(OP_READ, phy, ra, 16'h0000, rd);
  endtask

  task automatic mwr(input logic [4:0] phy, input logic [4:0] ra,
                     input logic [15:0] wd);
    logic [15:0] unused;
    u_mgmt.frame(OP_WRITE, phy, ra, wd, unused);
  endtask

  // Expected pause resolution: [1] transmit, [0] receive
  function automatic logic [1:0] exp_res(logic ls, logic la, logic ps,
                                         logic pa);
    exp_res[1] = (ls & ps) | (~ls & la & ps & pa);
    exp_res[0] = (ls & ps) | (ls & la & ~ps & pa);
  endfunction

  // Main sequence
  initial begin
    rst = 1'b1;
    an_done = 1'b0;
    lp_sym = 1'b0;
    lp_asym = 1'b0;
    errors = 0;
    cmp_count = 0;
    cycles = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    chk_word(adv_word, 16'h0141);
    chk_word(adv_z, 16'h00A1);
    chk_res(pause_res, 2'h0);
    chk_res({1'b0, ext_capable}, 2'h1);
    mrd(5'h01, REG_ID_UPPER);
    chk_word(rd, T_OUI[21:6]);
    mrd(5'h01, REG_ID_LOWER);
    chk_word(rd, {T_OUI[5:0], T_MODEL, T_REV});
    mrd(5'h02, REG_ID_UPPER);
    chk_word(rd, 16'h0000);
    mrd(5'h02, REG_ID_LOWER);
    chk_word(rd, 16'h0000);
    mwr(5'h01, REG_ID_UPPER, 16'hFFFF);
    mwr(5'h01, REG_ID_LOWER, 16'h0000);
    mrd(5'h01, REG_ID_UPPER);
    chk_word(rd, T_OUI[21:6]);
    mrd(5'h01, REG_ID_LOWER);
    chk_word(rd, {T_OUI[5:0], T_MODEL, T_REV});
    mrd(5'h01, REG_ADVERT);
    chk_word(rd, 16'h0141);
    mwr(5'h01, REG_ADVERT, 16'hFFFF);
    mrd(5'h01, REG_ADVERT);
    chk_word(rd, 16'hADFF);
    chk_word(adv_word, 16'hADFF);
    u_mgmt.half_clks = 9;
    mwr(5'h01, REG_ADVERT, 16'h0000);
    mrd(5'h01, REG_ADVERT);
    chk_word(rd, 16'h0000);
    u_mgmt.half_clks = 4;
    mrd(5'h01, 5'h1F);
    chk_word(rd, 16'h0000);
    mwr(5'h07, REG_ADVERT, 16'h0021);
    mrd(5'h07, REG_ADVERT);
    chk_word(rd, 16'hFFFF);
    chk_word(adv_word, 16'h0000);
    chk_word(adv_z, 16'h00A1);
    u_mgmt.frame(2'h3, 5'h01, REG_ADVERT, 16'hFFFF, rd);
    chk_word(rd, 16'hFFFF);
    chk_word(adv_word, 16'h0000);
    for (int l = 0; l < 4; l++) begin
      mwr(5'h01, REG_ADVERT, 16'h0001 | 16'(l << 10));
      for (int p = 0; p < 4; p++) begin
        @(posedge clk);
        lp_sym <= p[0];
        lp_asym <= p[1];
        an_done <= 1'b1;
        repeat (4) @(posedge clk);
        chk_res(pause_res, exp_res(l[0], l[1], p[0], p[1]));
      end
      an_done <= 1'b0;
      repeat (4) @(posedge clk);
      chk_res(pause_res, 2'h0);
    end
    end_of_test();
  end
endmodule // tb

`default_nettype wire
